// ---- stu_fifo.sv ----
/*
 Synchronous FIFO with parameterised width and depth, flip-flop storage.
 Assumes one clock, synchronous active-high reset, depth a power of two.
*/
`default_nettype none

module stu_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);

	localparam int AW = $clog2(DEPTH);

	// ----------------------------------------------------------------
	// Storage and pointers
	// ----------------------------------------------------------------
	logic [WIDTH-1:0] store [DEPTH];
	logic [AW-1:0]    wrPtr;
	logic [AW-1:0]    rdPtr;
	logic [AW:0]      count;
	wire logic        push;
	wire logic        pop;

	assign inReady  = (count != (AW+1)'(DEPTH));
	assign outValid = (count != '0);
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;
	assign outData  = store[rdPtr];

	// ----------------------------------------------------------------
	// Pointer and level update
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else begin
			if (push)
				wrPtr <= wrPtr + AW'(1);
			if (pop)
				rdPtr <= rdPtr + AW'(1);
			if (push && !pop)
				count <= count + (AW+1)'(1);
			else if (pop && !push)
				count <= count - (AW+1)'(1);
		end
	end

	// ----------------------------------------------------------------
	// Entry write, one per slot
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi++) begin : g_slot
			always_ff @(posedge clk) begin
				if (rst)
					store[gi] <= '0;
				else if (push && (wrPtr == AW'(gi)))
					store[gi] <= inData;
			end
		end
	endgenerate

endmodule : stu_fifo // stu_fifo

`default_nettype wire

// ---- stu_pkg.sv ----
/*
 Constants and types shared by the slope trigger unit and its sample FIFO.
 Assumes a single 20 MHz clock domain and a synchronous active-high reset.
*/
`default_nettype none

package stu_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int SAMPLE_W  = 16;
	localparam int DIFF_W    = 17;
	localparam int SPACING_W = 10;
	localparam int HIST_AW   = 10;
	localparam int HIST_N    = 1024;
	localparam int FILL_W    = 11;
	localparam int TCOUNT_W  = 16;

	// ----------------------------------------------------------------
	// Limits and depths
	// ----------------------------------------------------------------
	localparam logic [SPACING_W-1:0] SPACING_MAX = 10'h3ff;
	localparam int                   FIFO_DEPTH  = 16;
	localparam logic [FILL_W-1:0]    FILL_FULL   = 11'h400;
	localparam logic [TCOUNT_W-1:0]  TCOUNT_MAX  = 16'hffff;

	// ----------------------------------------------------------------
	// Values after reset
	// ----------------------------------------------------------------
	localparam logic [SAMPLE_W-1:0]  SAMPLE_RST  = 16'h0000;
	localparam logic [DIFF_W-1:0]    DIFF_RST    = 17'h00000;
	localparam logic [SPACING_W-1:0] SPACING_RST = 10'h000;
	localparam logic [HIST_AW-1:0]   PTR_RST     = 10'h000;
	localparam logic [FILL_W-1:0]    FILL_RST    = 11'h000;
	localparam logic [TCOUNT_W-1:0]  TCOUNT_RST  = 16'h0000;

	// ----------------------------------------------------------------
	// Detector states, Gray coded along sleep, fill, armed
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_SLEEP = 2'h0,
		ST_FILL  = 2'h1,
		ST_ARMED = 2'h3
	} stu_state_t;

endpackage : stu_pkg

`default_nettype wire

// ---- stu_sample_source.sv ----
/*
 Sample stream source standing in for the ADC side.
 Assumes the consumer's ready is settled by the falling edge.
*/
`default_nettype none

module stu_sample_source (
	input  wire logic                         clk,
	input  wire logic                         ready,
	output logic                              valid,
	output logic [stu_pkg::SAMPLE_W-1:0]      data
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		valid = 1'b0;
		data = 16'h0000;
	end

	// One offer per cycle, held when refused
	task automatic offer(input logic [15:0] v, output bit ok);
		@(negedge clk);
		valid = 1'b1;
		data = v;
		ok = ready;
		@(posedge clk);
	endtask

	task automatic send(input logic [15:0] v);
		bit ok;
		ok = 1'b0;
		while (!ok) offer(v, ok);
	endtask

	// Released data shows the inverse
	task automatic idle();
		@(negedge clk);
		valid = 1'b0;
		data = ~data;
	endtask
endmodule : stu_sample_source // stu_sample_source

`default_nettype wire

// ---- stu_slope_trigger.sv ----
/*
 Slope trigger unit: differences each sample against an earlier one and
 raises a trigger on a threshold crossing of that difference sequence.
 Assumes samples arrive synchronous to clk with a valid/ready handshake,
 and that the unit is reset together with the acquisition.
*/
// Functional notes
// RL1 - The sample taken spacing earlier is subtracted from each new sample.
// RL2 - Spacing is a 10-bit sample count, largest value 1023.
// RL3 - Threshold and spacing are separate inputs, never derived from each other.
// RL4 - No trigger while the difference has not reached the threshold.
// RL5 - Falling edge: difference at or below threshold, previous above it.
// RL6 - Edges are judged on the difference sequence, not raw samples.
// RL7 - Rising edge: difference at or above threshold, previous below it.
`default_nettype none

module stu_slope_trigger (
	input  wire logic                                 clk,
	input  wire logic                                 rst,
	input  wire logic                                 sampleValid,
	output logic                                      sampleReady,
	input  wire logic        [stu_pkg::SAMPLE_W-1:0]  sampleData,
	input  wire logic        [stu_pkg::SPACING_W-1:0] sample_spacing_count,
	input  wire logic signed [stu_pkg::DIFF_W-1:0]    amplitude_delta_threshold,
	input  wire logic                                 edgeFalling,
	input  wire logic                                 triggerEnable,
	input  wire logic                                 triggerClear,
	output logic                                      diffValid,
	input  wire logic                                 diffReady,
	output logic signed      [stu_pkg::DIFF_W-1:0]    diffData,
	output logic                                      diffTrigger,
	output logic                                      triggerSeen,
	output logic signed      [stu_pkg::DIFF_W-1:0]    triggerDiff,
	output logic             [stu_pkg::TCOUNT_W-1:0]  triggerCount,
	output logic                                      detectorArmed
);

	// ----------------------------------------------------------------
	// Sample FIFO in front of the detector
	// ----------------------------------------------------------------
	wire logic                         fifoValid;
	wire logic                         fifoReady;
	wire logic [stu_pkg::SAMPLE_W-1:0] fifoData;

	stu_fifo #(
		.WIDTH (stu_pkg::SAMPLE_W),
		.DEPTH (stu_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk      (clk),
		.rst      (rst),
		.inValid  (sampleValid),
		.inReady  (sampleReady),
		.inData   (sampleData),
		.outValid (fifoValid),
		.outReady (fifoReady),
		.outData  (fifoData)
	);

	// ----------------------------------------------------------------
	// Detector state
	// ----------------------------------------------------------------
	stu_pkg::stu_state_t state;
	stu_pkg::stu_state_t next_state;

	logic        [stu_pkg::SAMPLE_W-1:0]  hist [stu_pkg::HIST_N];
	logic        [stu_pkg::HIST_AW-1:0]   histPtr;
	logic        [stu_pkg::FILL_W-1:0]    fillCount;
	logic        [stu_pkg::SPACING_W-1:0] spacingHeld;
	logic signed [stu_pkg::DIFF_W-1:0]    prevDiff;

	// ----------------------------------------------------------------
	// Handshake towards the FIFO and the difference consumer
	// ----------------------------------------------------------------
	wire logic take;

	// Output stage free, or emptying at this edge
	assign fifoReady = !diffValid || diffReady;
	assign take      = fifoValid && fifoReady;

	// ----------------------------------------------------------------
	// Reference sample lookup
	// ----------------------------------------------------------------
	wire logic [stu_pkg::HIST_AW-1:0]  refIdx;
	wire logic [stu_pkg::SAMPLE_W-1:0] refHist;
	wire logic [stu_pkg::SAMPLE_W-1:0] refSample;
	wire logic                         spacingZero;
	wire logic                         spacingMoved;
	wire logic                         refReady;

	assign spacingZero  = (sample_spacing_count == '0);
	assign spacingMoved = (sample_spacing_count != spacingHeld);
	assign refIdx       = histPtr - stu_pkg::HIST_AW'(sample_spacing_count); // RL2
	assign refHist      = hist[refIdx];
	// Spacing zero compares a sample with itself
	assign refSample    = spacingZero ? fifoData : refHist;
	assign refReady     = (fillCount >= stu_pkg::FILL_W'(sample_spacing_count)); // RL2

	// ----------------------------------------------------------------
	// Difference of current and earlier sample
	// ----------------------------------------------------------------
	wire logic signed [stu_pkg::DIFF_W-1:0] curExt;
	wire logic signed [stu_pkg::DIFF_W-1:0] refExt;
	wire logic signed [stu_pkg::DIFF_W-1:0] diffNow;

	assign curExt  = {fifoData[stu_pkg::SAMPLE_W-1], fifoData};
	assign refExt  = {refSample[stu_pkg::SAMPLE_W-1], refSample};
	assign diffNow = curExt - refExt; // RL1

	// ----------------------------------------------------------------
	// Threshold crossing on the difference sequence
	// ----------------------------------------------------------------
	wire logic curAtOrAbove;
	wire logic curAtOrBelow;
	wire logic prevBelow;
	wire logic prevAbove;
	wire logic riseHit;
	wire logic fallHit;
	wire logic edgeHit;
	wire logic armedNow;
	wire logic trigNow;

	// Both sides of the threshold are needed, so a level alone never fires
	assign curAtOrAbove = (diffNow >= amplitude_delta_threshold); // RL4
	assign curAtOrBelow = (diffNow <= amplitude_delta_threshold); // RL4
	assign prevBelow    = (prevDiff < amplitude_delta_threshold);
	assign prevAbove    = (prevDiff > amplitude_delta_threshold);
	assign riseHit      = curAtOrAbove && prevBelow; // RL7
	assign fallHit      = curAtOrBelow && prevAbove; // RL5
	assign edgeHit      = edgeFalling ? fallHit : riseHit; // RL6
	assign armedNow     = (state == stu_pkg::ST_ARMED) && !spacingMoved;
	assign trigNow      = take && armedNow && edgeHit; // RL4

	// ----------------------------------------------------------------
	// State transitions
	// ----------------------------------------------------------------
	wire logic seedTaken;

	// First referenced sample only seeds the previous difference
	assign seedTaken = take && refReady && !spacingMoved; // RL4

	always_comb begin
		next_state = state;
		case (state)
			stu_pkg::ST_SLEEP: begin
				if (triggerEnable)
					next_state = stu_pkg::ST_FILL;
			end
			stu_pkg::ST_FILL: begin
				if (!triggerEnable)
					next_state = stu_pkg::ST_SLEEP;
				else if (seedTaken)
					next_state = stu_pkg::ST_ARMED;
			end
			stu_pkg::ST_ARMED: begin
				if (!triggerEnable)
					next_state = stu_pkg::ST_SLEEP;
				else if (spacingMoved)
					next_state = stu_pkg::ST_FILL;
			end
			default: begin
				next_state = stu_pkg::ST_SLEEP;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst)
			state <= stu_pkg::ST_SLEEP;
		else
			state <= next_state;
	end

	assign detectorArmed = (state == stu_pkg::ST_ARMED);

	// ----------------------------------------------------------------
	// History of past samples, one slot per entry
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < stu_pkg::HIST_N; gi++) begin : g_hist
			always_ff @(posedge clk) begin
				if (rst)
					hist[gi] <= stu_pkg::SAMPLE_RST;
				else if (take && (histPtr == stu_pkg::HIST_AW'(gi)))
					hist[gi] <= fifoData;
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// History pointer and fill level
	// ----------------------------------------------------------------
	wire logic                        fillSat;
	wire logic [stu_pkg::HIST_AW-1:0] next_histPtr;
	wire logic [stu_pkg::FILL_W-1:0]  next_fillCount;

	assign fillSat        = (fillCount == stu_pkg::FILL_FULL);
	assign next_histPtr   = take ? histPtr + stu_pkg::HIST_AW'(1) : histPtr;
	assign next_fillCount = (take && !fillSat) ? fillCount + stu_pkg::FILL_W'(1) : fillCount;

	always_ff @(posedge clk) begin
		if (rst)
			histPtr <= stu_pkg::PTR_RST;
		else
			histPtr <= next_histPtr;
	end

	always_ff @(posedge clk) begin
		if (rst)
			fillCount <= stu_pkg::FILL_RST;
		else
			fillCount <= next_fillCount;
	end

	// ----------------------------------------------------------------
	// Held spacing, compared each cycle to see it move
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst)
			spacingHeld <= stu_pkg::SPACING_RST;
		else
			spacingHeld <= sample_spacing_count; // RL3
	end

	// ----------------------------------------------------------------
	// Previous difference, kept for the edge test
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst)
			prevDiff <= stu_pkg::DIFF_RST;
		else if (take)
			prevDiff <= diffNow; // RL6
	end

	// ----------------------------------------------------------------
	// Difference output stage: flags
	// ----------------------------------------------------------------
	wire logic beatDrop;

	assign beatDrop = !take && diffReady;

	always_ff @(posedge clk) begin
		if (rst) begin
			diffValid   <= 1'b0;
			diffTrigger <= 1'b0;
		end else if (take) begin
			diffValid   <= refReady;
			diffTrigger <= trigNow; // RL4
		end else if (beatDrop) begin
			diffValid   <= 1'b0;
			diffTrigger <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Difference output stage: data, held until the next load
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst)
			diffData <= stu_pkg::DIFF_RST;
		else if (take)
			diffData <= diffNow; // RL1
	end

	// ----------------------------------------------------------------
	// Trigger record: sticky flag and last difference
	// ----------------------------------------------------------------
	wire logic next_triggerSeen;

	// A trigger in the clearing cycle must not be lost, so set wins
	assign next_triggerSeen = trigNow || (triggerSeen && !triggerClear);

	always_ff @(posedge clk) begin
		if (rst)
			triggerSeen <= 1'b0;
		else
			triggerSeen <= next_triggerSeen; // RL4
	end

	always_ff @(posedge clk) begin
		if (rst)
			triggerDiff <= stu_pkg::DIFF_RST;
		else if (trigNow)
			triggerDiff <= diffNow; // RL6
	end

	// ----------------------------------------------------------------
	// Trigger count, saturating
	// ----------------------------------------------------------------
	wire logic                         countSat;
	wire logic [stu_pkg::TCOUNT_W-1:0] next_triggerCount;

	assign countSat          = (triggerCount == stu_pkg::TCOUNT_MAX);
	assign next_triggerCount = (trigNow && !countSat)
		? triggerCount + stu_pkg::TCOUNT_W'(1) : triggerCount;

	always_ff @(posedge clk) begin
		if (rst)
			triggerCount <= stu_pkg::TCOUNT_RST;
		else
			triggerCount <= next_triggerCount;
	end

endmodule : stu_slope_trigger // stu_slope_trigger

`default_nettype wire

// ---- stu_slope_trigger_sva.sv ----
/*
 Port checker for the slope trigger unit.
 Assumes one clock and a synchronous active-high reset; bound below.
*/
`default_nettype none

module stu_slope_trigger_sva (
	input wire logic                                 clk,
	input wire logic                                 rst,
	input wire logic                                 sampleValid,
	input wire logic                                 sampleReady,
	input wire logic        [stu_pkg::SPACING_W-1:0] sample_spacing_count,
	input wire logic signed [stu_pkg::DIFF_W-1:0]    amplitude_delta_threshold,
	input wire logic                                 edgeFalling,
	input wire logic                                 diffValid,
	input wire logic                                 diffReady,
	input wire logic signed [stu_pkg::DIFF_W-1:0]    diffData,
	input wire logic                                 diffTrigger,
	input wire logic signed [stu_pkg::DIFF_W-1:0]    triggerDiff,
	input wire logic        [stu_pkg::TCOUNT_W-1:0]  triggerCount,
	input wire logic                                 detectorArmed
);
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	logic signed [stu_pkg::DIFF_W-1:0] lastD;
	logic        [1:0]                 stCnt;

	always_ff @(posedge clk) begin
		if (rst) begin
			lastD <= '0;
			stCnt <= 2'h0;
		end else begin
			if (diffValid && diffReady) lastD <= diffData;
			if ($changed(sample_spacing_count)) stCnt <= 2'h0;
			else if (stCnt != 2'h3) stCnt <= stCnt + 2'h1;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	property p_riseTrig;
		diffValid && diffTrigger && !edgeFalling |->
			diffData >= amplitude_delta_threshold && lastD < amplitude_delta_threshold;
	endproperty
	property p_fallTrig;
		diffValid && diffTrigger && edgeFalling |->
			diffData <= amplitude_delta_threshold && lastD > amplitude_delta_threshold;
	endproperty
	property p_belowThr;
		diffValid && !edgeFalling && diffData < amplitude_delta_threshold |-> !diffTrigger;
	endproperty
	property p_trigDiff;
		diffValid && diffTrigger |-> triggerDiff == diffData;
	endproperty
	property p_zeroSpace;
		diffValid && stCnt == 2'h3 && sample_spacing_count == 10'h000 |-> diffData == 17'h00000;
	endproperty
	property p_spaceRearm;
		$changed(sample_spacing_count) |=> !detectorArmed;
	endproperty
	property p_cntStep;
		triggerCount != $past(triggerCount) |->
			triggerCount == $past(triggerCount) + 16'h0001 && diffValid && diffTrigger;
	endproperty

	a_riseTrig: assert property (p_riseTrig) else $error("rising trigger off");
	a_fallTrig: assert property (p_fallTrig) else $error("falling trigger off");
	a_belowThr: assert property (p_belowThr) else $error("trigger below threshold");
	a_trigDiff: assert property (p_trigDiff) else $error("trigger diff mismatch");
	a_zeroSpace: assert property (p_zeroSpace) else $error("spacing zero diff");
	a_spaceRearm: assert property (p_spaceRearm) else $error("armed after change");
	a_cntStep: assert property (p_cntStep) else $error("trigger count step");

	c_rise: cover property (diffValid && diffTrigger && !edgeFalling);
	c_fall: cover property (diffValid && diffTrigger && edgeFalling);
	c_full: cover property (sampleValid && !sampleReady);
endmodule : stu_slope_trigger_sva // stu_slope_trigger_sva

bind stu_slope_trigger stu_slope_trigger_sva u_sva (.clk, .rst, .sampleValid, .sampleReady,
	.sample_spacing_count, .amplitude_delta_threshold, .edgeFalling, .diffValid, .diffReady,
	.diffData, .diffTrigger, .triggerDiff, .triggerCount, .detectorArmed);

`default_nettype wire

// ---- test_slope_trigger_unit.sv ----
/*
 Self-checking bench for the slope trigger unit.
 Assumes the sample source model and the bound checker.
*/
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; \
	$display("Error at %0t got %h exp %h", $time, a, b); end end

module test_slope_trigger_unit;
	timeunit 1ns;
	timeprecision 1ns;

	logic clk, rst, sVal, sRdy, edgeF, en, clr, dVal, dRdy, dTrig, seen, armed;
	logic [15:0] sDat, tCnt;
	logic [9:0] spacing;
	logic signed [16:0] thresh, dDat, tDiff;
	logic signed [16:0] gd[$];
	logic gt[$];
	logic [15:0] smp[0:1099];
	int fail_count, compares, expTrig, cyc;

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	stu_slope_trigger DUT (.clk(clk), .rst(rst), .sampleValid(sVal), .sampleReady(sRdy),
		.sampleData(sDat), .sample_spacing_count(spacing), .amplitude_delta_threshold(thresh),
		.edgeFalling(edgeF), .triggerEnable(en), .triggerClear(clr), .diffValid(dVal),
		.diffReady(dRdy), .diffData(dDat), .diffTrigger(dTrig), .triggerSeen(seen),
		.triggerDiff(tDiff), .triggerCount(tCnt), .detectorArmed(armed));
	stu_sample_source src (.clk(clk), .ready(sRdy), .valid(sVal), .data(sDat));

	always @(posedge clk) begin
		if (!rst && dVal === 1'b1 && dRdy === 1'b1) begin
			gd.push_back(dDat);
			gt.push_back(dTrig);
		end
		cyc++;
		if (cyc == 4000) begin
			fail_count++;
			summarize();
		end
	end

	task automatic summarize();
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	task automatic restart(input int sp, input logic signed [16:0] thr, input logic fall);
		@(negedge clk);
		rst = 1'b1;
		spacing = sp[9:0];
		thresh = thr;
		edgeF = fall;
		dRdy = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		gd.delete();
		gt.delete();
		repeat (2) @(negedge clk);
	endtask

	// Sends smp[0..n-1] and compares every beat with the model
	task automatic run(input int sp, input int n, input logic signed [16:0] thr,
		input logic fall);
		logic signed [16:0] d, p;
		logic t;
		int nb;
		restart(sp, thr, fall);
		for (int k = 0; k < n; k++) src.send(smp[k]);
		src.idle();
		repeat (8) @(negedge clk);
		nb = 0;
		expTrig = 0;
		p = '0;
		for (int k = sp; k < n; k++) begin
			d = $signed({smp[k][15], smp[k]}) - $signed({smp[k-sp][15], smp[k-sp]});
			t = (k > sp) && (fall ? (d <= thr && p > thr) : (d >= thr && p < thr));
			`CHK(gd[nb], d)
			`CHK(gt[nb], t)
			nb++;
			expTrig += t;
			p = d;
		end
		`CHK(gd.size(), nb)
	endtask

	task automatic t_rising();
		logic [15:0] v[6] = '{16'h0032, 16'h0028, 16'h0026, 16'h002c, 16'h002c, 16'h0033};
		foreach (v[i]) smp[i] = v[i];
		run(1, 6, 17'sd6, 1'b0);
		`CHK(tCnt, expTrig[15:0])
		`CHK(tDiff, 17'h00007)
		@(negedge clk);
		clr = 1'b1;
		spacing = 10'h002;
		@(negedge clk);
		clr = 1'b0;
		@(negedge clk);
		`CHK(seen, 1'b0)
		`CHK(armed, 1'b0)
		$display("t_rising done");
	endtask

	task automatic t_falling();
		logic [15:0] v[10] = '{16'h0064, 16'h0064, 16'h0062, 16'h0061, 16'h005d, 16'h0061,
			16'h0059, 16'h0061, 16'h005d, 16'h005d};
		foreach (v[i]) smp[i] = v[i];
		run(2, 10, -17'sd4, 1'b1);
		`CHK(tCnt, 16'h0003)
		`CHK(tDiff, 17'h1fffc)
		`CHK(seen, 1'b1)
		`CHK(armed, 1'b1)
		en = 1'b0;
		@(negedge clk);
		`CHK(armed, 1'b0)
		en = 1'b1;
		$display("t_falling done");
	endtask

	task automatic t_spanmax();
		for (int i = 0; i < 1026; i++) smp[i] = i[15:0];
		run(1023, 1026, 17'sd2000, 1'b0);
		`CHK(gd[0], 17'h003ff)
		`CHK(tCnt, 16'h0000)
		$display("t_spanmax done");
	endtask

	task automatic t_fill();
		int n;
		bit ok;
		restart(0, 17'sd100, 1'b0);
		dRdy = 1'b0;
		n = 0;
		ok = 1'b1;
		while (ok && n < 40) begin
			src.offer(n[15:0], ok);
			if (ok) n++;
		end
		@(negedge clk);
		`CHK(n, stu_pkg::FIFO_DEPTH + 1)
		`CHK(sRdy, 1'b0)
		dRdy = 1'b1;
		src.send(n[15:0]);
		src.idle();
		repeat (24) @(negedge clk);
		`CHK(gd.size(), n + 1)
		foreach (gd[i]) `CHK(gd[i], 17'h00000)
		$display("t_fill done");
	endtask

	initial begin
		rst = 1'b1;
		spacing = 10'h000;
		thresh = 17'h00000;
		edgeF = 1'b0;
		en = 1'b1;
		clr = 1'b0;
		dRdy = 1'b1;
		repeat (20) @(negedge clk);
		rst = 1'b0;
		t_rising();
		t_falling();
		t_spanmax();
		t_fill();
		summarize();
	end
endmodule : test_slope_trigger_unit // test_slope_trigger_unit

`default_nettype wire
